// *** pkg/ios_pkg.sv ***
// Constants and carrier types for the isolated octal switch serial control.
package ios_pkg;
    localparam int          CHAN_W       = 8;
    localparam int          CNT_W        = 3;
    localparam logic [2:0]  CNT_ZERO     = 3'h0;
    localparam logic [2:0]  CNT_ONE      = 3'h1;
    localparam logic [1:0]  REJ_ZERO     = 2'h0;
    localparam logic [1:0]  REJ_ONE      = 2'h1;
    localparam logic [1:0]  REJ_LIMIT    = 2'h3;
    localparam logic [7:0]  PAT_RESET    = 8'h00;
    localparam int          SETTLE_NS    = 1000;
    localparam int          CLK_NS       = 100;
    localparam int          SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  SETTLE_LAST  = 4'(SETTLE_CYC - 1);

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic si;
    } ios_link_type;

    typedef struct packed {
        logic so;
        logic so_oe;
    } ios_so_type;
endpackage

// *** hdl/ios_sync2.sv ***
// Two-stage synchroniser for a group of level inputs.
module ios_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    input  wire logic [W-1:0] rst_val_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // The flops hold each input relative to its idle level, so reset
    // assigns only zeros and the output still wakes up at the idle level.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= d_in ^ rst_val_in;
            q_reg    <= meta_reg;
        end
    end

    assign q_out = q_reg ^ rst_val_in;
endmodule

// *** hdl/ios_serial_ctrl.sv ***
// Serial channel control: shift register, modulo counter, latch and fault.
module ios_serial_ctrl
    import ios_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              arst_n_in,
    input  wire logic              outputs_off_n_in,
    input  wire logic              cs_n_in,
    input  wire logic              sclk_in,
    input  wire logic              si_in,
    input  wire logic [CHAN_W-1:0] overtemp_in,
    input  wire logic              vbb_low_in,
    input  wire logic              xfer_reject_in,
    output logic                   so_out,
    output logic                   so_oe_out,
    output logic [CHAN_W-1:0]      channel_drive_out,
    output logic                   fault_flag_n_out
);
    typedef struct packed {
        logic [CHAN_W-1:0] shift;
        logic [CNT_W-1:0]  cnt;
        logic              clocked;
        logic [CHAN_W-1:0] pattern;
        logic              valid;
        logic [1:0]        rejects;
        logic              sclk_d;
        logic              cs_n_d;
        logic              so;
        logic              so_oe;
        logic [CHAN_W-1:0] drive;
        logic              fault_n;
        logic [3:0]        settle;
        logic              ready;
    } ios_state_type;

    ios_state_type st_reg;
    ios_state_type st_next;
    logic [1:0]    rst_sync_reg;
    logic          rst_n;
    ios_link_type  link_raw;
    ios_link_type  link;
    logic          kill_n;
    logic [CHAN_W-1:0] ot;
    logic          vlow;
    logic          rej;
    logic          sclk_rise;
    logic          sclk_fall;
    logic          cs_rise;
    logic          cs_fall;

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    assign link_raw = '{cs_n: cs_n_in, sclk: sclk_in, si: si_in};

    ios_sync2 #(.W(3 + 1 + CHAN_W + 1 + 1)) u_sync (
        .clk_in     (clk_sys_in),
        .rst_n_in   (rst_n),
        .d_in       ({link_raw, outputs_off_n_in, overtemp_in, vbb_low_in,
                      xfer_reject_in}),
        // Select, serial clock and kill idle high, so no false edge
        // and no spurious selection follow the release of reset.
        .rst_val_in ({3'h6, 1'h1, {CHAN_W{1'b0}}, 2'h0}),
        .q_out      ({link, kill_n, ot, vlow, rej})
    );

    assign sclk_rise = link.sclk && !st_reg.sclk_d && !link.cs_n;
    assign sclk_fall = !link.sclk && st_reg.sclk_d && !link.cs_n;
    assign cs_rise   = link.cs_n && !st_reg.cs_n_d;
    assign cs_fall   = !link.cs_n && st_reg.cs_n_d;

    always_comb begin
        st_next        = st_reg;
        st_next.sclk_d = link.sclk;
        st_next.cs_n_d = link.cs_n;
        if (!st_reg.ready) begin
            if (st_reg.settle == SETTLE_LAST) begin
                st_next.ready = 1'b1;
            end else begin
                st_next.settle = st_reg.settle + 4'h1;
            end
        end
        if (cs_fall) begin
            st_next.cnt     = CNT_ZERO;
            st_next.clocked = 1'b0;
            st_next.so      = st_reg.shift[CHAN_W-1];
        end
        if (sclk_rise) begin
            st_next.shift   = {st_reg.shift[CHAN_W-2:0], link.si};
            st_next.cnt     = st_reg.cnt + CNT_ONE;
            st_next.clocked = 1'b1;
        end
        if (sclk_fall) begin
            st_next.so = st_reg.shift[CHAN_W-1];
        end
        st_next.so_oe = !link.cs_n;
        if (cs_rise && st_reg.clocked && st_reg.cnt == CNT_ZERO) begin
            st_next.pattern = st_reg.shift;
            st_next.valid   = 1'b1;
            st_next.rejects = REJ_ZERO;
        end else if (rej) begin
            if (st_reg.rejects == REJ_LIMIT) begin
                st_next.valid = 1'b0;
            end else begin
                st_next.rejects = st_reg.rejects + REJ_ONE;
            end
        end
        if (!kill_n) begin
            st_next.shift   = PAT_RESET;
            st_next.pattern = PAT_RESET;
            st_next.cnt     = CNT_ZERO;
            st_next.clocked = 1'b0;
            st_next.valid   = 1'b0;
            st_next.rejects = REJ_ZERO;
        end
        st_next.drive = (st_next.valid && st_reg.ready && kill_n)
                        ? st_next.pattern : PAT_RESET;
        st_next.fault_n = !((|ot) || vlow);
    end

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.sclk_d  <= 1'b1;
            st_reg.cs_n_d  <= 1'b1;
            st_reg.fault_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign so_out           = st_reg.so;
    assign so_oe_out        = st_reg.so_oe;
    assign channel_drive_out = outputs_off_n_in ? st_reg.drive : PAT_RESET;
    assign fault_flag_n_out = st_reg.fault_n;

    // Two-step write: select fall then select rise on a full byte.
    sequence byte_done_s;
        cs_rise && st_reg.clocked && st_reg.cnt == CNT_ZERO && kill_n;
    endsequence

    latch_on_byte_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        byte_done_s |=> st_reg.pattern == $past(st_reg.shift))
        else $error("pattern not latched after full byte");

    no_latch_odd_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        (cs_rise && (st_reg.cnt != CNT_ZERO || !st_reg.clocked) && kill_n)
        |=> $stable(st_reg.pattern))
        else $error("pattern latched on partial byte");

    kill_clears_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        !kill_n |=> st_reg.pattern == PAT_RESET && !st_reg.valid)
        else $error("kill did not clear pattern");

    kill_off_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        !outputs_off_n_in |-> channel_drive_out == PAT_RESET)
        else $error("channels on while killed");

    kill_reg_off_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        !kill_n |=> st_reg.drive == PAT_RESET)
        else $error("drive register on while killed");

    stay_off_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        !st_reg.valid |-> st_reg.drive == PAT_RESET)
        else $error("channels on without valid pattern");

    so_hiz_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        link.cs_n |=> !so_oe_out)
        else $error("serial output driven while deselected");

    so_on_fall_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        (!so_oe_out || $stable(so_out) || $past(sclk_fall) || $past(cs_fall))
        || !$past(so_oe_out))
        else $error("serial output changed without sclk fall");

    fault_or_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        (|ot) |=> !fault_flag_n_out)
        else $error("fault flag missed overtemperature");

    fault_vbb_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        (!(|ot) && !vlow) |=> fault_flag_n_out)
        else $error("fault flag low in normal operation");

    vbb_low_flag_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        vlow |=> !fault_flag_n_out)
        else $error("fault flag missed low load supply");

    settle_off_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        !st_reg.ready |=> st_reg.drive == PAT_RESET)
        else $error("outputs on before input stage settled");

    reject_off_a: assert property (
        @(posedge clk_sys_in) disable iff (!rst_n)
        (rej && st_reg.rejects == REJ_LIMIT && !cs_rise) |=> !st_reg.valid)
        else $error("outputs not off after four rejects");
endmodule

// *** dv/ios_spi_master.sv ***
// Serial master model that drives frames into the switch control.
module ios_spi_master (
    input  wire logic clk_sys_in,
    input  wire logic so_in,
    input  wire logic so_oe_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      si_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] so_bits = 16'h0000;
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        si_out   = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge clk_sys_in);
    endtask
    task automatic send(input logic [15:0] data, input int n);
        so_bits  = 16'h0000;
        cs_n_out = 1'b0;
        half();
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out = 1'b0;
            si_out   = data[i];
            half();
            sclk_out = 1'b1;
            // An undriven output reads as the inverse, so a late enable shows.
            so_bits  = {so_bits[14:0], so_oe_in ? so_in : ~so_in};
            half();
        end
        cs_n_out = 1'b1;
        // A deselected data line must not look like a held bit.
        si_out = ~si_out;
        half();
    endtask
endmodule

// *** dv/test_ios_serial_ctrl.sv ***
// Self-checking bench for the serial channel control.
module test_ios_serial_ctrl
    import ios_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk_sys_in       = 1'b0;
    logic              arst_n_in        = 1'b0;
    logic              outputs_off_n_in = 1'b1;
    logic [CHAN_W-1:0] overtemp_in      = 8'h00;
    logic              vbb_low_in       = 1'b0;
    logic              xfer_reject_in   = 1'b0;
    logic              cs_n, sclk, si, so, so_oe, fault_n;
    logic [CHAN_W-1:0] drive;
    int                error_cnt = 0;
    int                n_tests   = 0;
    int                cycles    = 0;

    always #50 clk_sys_in = ~clk_sys_in;

    ios_spi_master ios_spi_master_inst (.clk_sys_in(clk_sys_in),
        .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n),
        .sclk_out(sclk), .si_out(si));
    ios_serial_ctrl ios_serial_ctrl_inst (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .outputs_off_n_in(outputs_off_n_in),
        .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si),
        .overtemp_in(overtemp_in), .vbb_low_in(vbb_low_in),
        .xfer_reject_in(xfer_reject_in), .so_out(so), .so_oe_out(so_oe),
        .channel_drive_out(drive), .fault_flag_n_out(fault_n));

    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic frame(input logic [15:0] d, input int n);
        ios_spi_master_inst.send(d, n);
        idle(6);
    endtask
    task automatic t_reset();
        check(drive, 8'h00);
        check({7'h00, fault_n}, 8'h01);
        check({7'h00, so_oe}, 8'h00);
    endtask
    task automatic t_daisy();
        frame(16'h3ca5, 16);
        check(drive, 8'ha5);
        check(ios_spi_master_inst.so_bits, 16'h003c);
        check({7'h00, so_oe}, 8'h00);
    endtask
    task automatic t_refuse();
        frame(16'h00ff, 7);
        check(drive, 8'ha5);
        frame(16'h0000, 0);
        check(drive, 8'ha5);
    endtask
    task automatic t_kill();
        outputs_off_n_in = 1'b0;
        #1;
        check(drive, 8'h00);
        idle(3);
        outputs_off_n_in = 1'b1;
        idle(6);
        check(drive, 8'h00);
        frame(16'h0081, 8);
        check(ios_spi_master_inst.so_bits[7:0], 8'h00);
        check(drive, 8'h81);
    endtask
    task automatic t_fault();
        for (int i = 0; i < CHAN_W; i++) begin
            overtemp_in = 8'h01 << i;
            idle(6);
            check({7'h00, fault_n}, 8'h00);
            overtemp_in = 8'h00;
            idle(6);
            check({7'h00, fault_n}, 8'h01);
        end
        vbb_low_in = 1'b1;
        idle(6);
        check({7'h00, fault_n}, 8'h00);
        vbb_low_in = 1'b0;
        idle(6);
    endtask
    task automatic t_reject();
        for (int i = 1; i <= 4; i++) begin
            xfer_reject_in = 1'b1;
            idle(1);
            xfer_reject_in = 1'b0;
            idle(4);
            check(drive, (i < 4) ? 8'h81 : 8'h00);
        end
        frame(16'h0042, 8);
        check(drive, 8'h42);
    endtask

    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        idle(4);
        arst_n_in = 1'b1;
        idle(20);
        t_reset();
        t_daisy();
        t_refuse();
        t_kill();
        t_fault();
        t_reject();
        conclude();
    end
endmodule
